/* hw/pse_regs_pkg.sv */
// Constants and types shared by the port mode and address register block
package pse_regs_pkg;

  // ****************************************
  // Command codes and reset values
  // ****************************************
  localparam logic [7:0] CMD_STRAP_STATUS   = 8'h11;
  localparam logic [7:0] CMD_PORT_MODE      = 8'h12;
  localparam logic [7:0] CMD_DISC_ENABLE    = 8'h13;
  localparam logic [7:0] PORT_MODE_RESET    = 8'h00;
  localparam logic [3:0] DISC_ENABLE_RESET  = 4'h0;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  // ****************************************
  // Address layout
  // ****************************************
  localparam logic [1:0] ADDR_PREFIX        = 2'h1;
  localparam logic [6:0] BROADCAST_ADDR     = 7'h7F;
  localparam logic [1:0] STATUS_LOW_ZEROS   = 2'h0;

  // ****************************************
  // Port mode field
  // ****************************************
  localparam int         NUM_PORTS          = 4;
  localparam int         MODE_W             = 2;
  localparam logic [1:0] MODE_OFF           = 2'h0;
  localparam logic [1:0] MODE_MANUAL        = 2'h1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         CLK_HZ             = 100_000_000;
  localparam int         TICK_MS            = 1;
  localparam int         TICK_CYCLES        = CLK_HZ / 1000 * TICK_MS;
  localparam int         DISC_HOLD_MS       = 15;
  localparam int         DISC_TIMEOUT_MS    = 300;
  localparam logic [3:0] BYTE_BITS          = 4'h8;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_CMD       = 9'h008,
    ST_CMD_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RDATA_ACK = 9'h100
  } serial_state_type;

endpackage

/* hw/pse_port_mode_regs.sv */
// Serial slave with port mode, disconnect enable and strap address registers
// Operation
// RQ1: Status bits 6-2 give strap slave address.
// RQ2: Always answer the all-ones broadcast address; the code answers it for writes only.
// RQ3: Lowest address bit fixed internally, not pin.
// RQ4: Mode register at command 12h, read/write.
// RQ5: Two bits per port: off, manual, semiauto.
// RQ6: Manual no auto steps; power only on command.
// RQ7: Off mode holds port events and faults cleared.
// RQ8: Off mode clears results, enables, power fault.
// RQ9: Entering off drops port-on and power-good.
// RQ10: Off-caused change sets the change events.
// RQ11: Disconnect enable at command 13h, read/write.
// RQ12: Address status at 11h, writes ignored.
// RQ13: Low current timeout turns port off, flags fault.
// RQ14: Reset puts every port in off mode.
module pse_port_mode_regs
  import pse_regs_pkg::*;
#(
  parameter logic       ADDR_LSB        = 1'b0,        // Internally fixed low address bit
  parameter int         MS_TICK_CYCLES  = TICK_CYCLES, // Clock cycles per millisecond tick
  parameter int         DISC_TIMEOUT    = DISC_TIMEOUT_MS
) (
  input  wire logic       clk,                          // System clock, 100 MHz
  input  wire logic       nrst,                         // Asynchronous reset, active low
  input  wire logic       scl_in,                       // Serial clock pin
  input  wire logic       sda_in,                       // Serial data pin level
  output logic            sda_out,                      // Serial data drive value
  output logic            sda_oe,                       // Serial data drive enable
  input  wire logic [3:0] address_strap_pins,           // Address strap pins
  input  wire logic [3:0] power_on_cmd,                 // Host power-on command per port
  input  wire logic [3:0] power_on_set,                 // Switch engine reports port on
  input  wire logic [3:0] power_off_set,                // Switch engine reports port off
  input  wire logic [3:0] power_good_set,               // Drain reached power good
  input  wire logic [3:0] current_low,                  // Sensed current under threshold
  input  wire logic [3:0] change_event_clear,           // Clear of both change events
  output logic      [7:0] port_mode,                    // Mode register contents
  output logic      [3:0] dc_drop_off_enable,           // Disconnect enable bits
  output logic      [3:0] off_hold,                     // Port in off mode, hold bits cleared
  output logic      [3:0] auto_cycle_en,                // Engines may detect and classify alone
  output logic      [3:0] power_on_req,                 // Request to switch port power on
  output logic      [3:0] disconnect_fault_flag,        // Disconnect fault set pulse
  output logic      [3:0] port_on_flag,                 // Port powered
  output logic      [3:0] power_good_flag,              // Port power good
  output logic      [3:0] port_on_change_event,         // Port-on state changed
  output logic      [3:0] power_good_change_event       // Power-good state changed
);

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      strap_s1_r <= 4'h0;
      strap_s2_r <= 4'h0;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], scl_in};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
      strap_s1_r <= address_strap_pins;
      strap_s2_r <= strap_s1_r;
    end
  end

  // Edges look only at the second and third stages
  assign scl_rise  = scl_sync_r[1] & ~scl_sync_r[2];
  assign scl_fall  = ~scl_sync_r[1] & scl_sync_r[2];
  assign bus_start = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[2] & ~sda_sync_r[1];
  assign bus_stop  = scl_sync_r[1] & scl_sync_r[2] & ~sda_sync_r[2] & sda_sync_r[1];

  // ****************************************
  // Address match and read data
  // ****************************************
  serial_state_type state_r;
  logic [7:0]       shift_r;
  logic [3:0]       bit_cnt_r;
  logic [7:0]       cmd_r;
  logic             master_ack_r;
  logic             sda_oe_r;
  logic             sda_out_r;
  logic [6:0]       own_addr;
  logic             addr_match;
  logic [7:0]       status_byte;
  logic [7:0]       rd_byte;
  logic             byte_done;
  logic             wr_fire;
  logic [7:0]       port_mode_r;
  logic [3:0]       disc_en_r;

  // RQ1: strap address field
  // RQ3: internal low bit
  assign own_addr    = {ADDR_PREFIX, strap_s2_r, ADDR_LSB};
  assign status_byte = {1'b0, strap_s2_r, ADDR_LSB, STATUS_LOW_ZEROS};
  // RQ2: broadcast match
  // Broadcast reads would collide between devices, so only writes answer there
  assign addr_match  = (shift_r[7:1] == own_addr) |
                       ((shift_r[7:1] == BROADCAST_ADDR) & ~shift_r[0]);
  assign byte_done   = scl_fall & (bit_cnt_r == BYTE_BITS);

  always_comb begin
    unique case (cmd_r)
      // RQ12: status read
      CMD_STRAP_STATUS: rd_byte = status_byte;
      CMD_PORT_MODE:    rd_byte = port_mode_r;
      CMD_DISC_ENABLE:  rd_byte = {4'h0, disc_en_r};
      default:          rd_byte = UNMAPPED_READ;
    endcase
  end

  // ****************************************
  // Serial slave sequencer
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r      <= ST_IDLE;
      shift_r      <= 8'h00;
      bit_cnt_r    <= 4'h0;
      cmd_r        <= 8'h00;
      master_ack_r <= 1'b0;
      sda_oe_r     <= 1'b0;
    end else if (bus_start) begin
      state_r   <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r  <= 1'b0;
    end else if (bus_stop) begin
      state_r  <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise && bit_cnt_r != BYTE_BITS) begin
            shift_r   <= {shift_r[6:0], sda_sync_r[1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (byte_done) begin
            bit_cnt_r <= 4'h0;
            if (state_r == ST_ADDR) begin
              sda_oe_r <= addr_match;
              state_r  <= addr_match ? ST_ADDR_ACK : ST_IDLE;
            end else if (state_r == ST_CMD) begin
              cmd_r    <= shift_r;
              sda_oe_r <= 1'b1;
              state_r  <= ST_CMD_ACK;
            end else begin
              sda_oe_r <= 1'b1;
              state_r  <= ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (shift_r[0]) begin
              shift_r   <= {rd_byte[6:0], 1'b0};
              sda_oe_r  <= ~rd_byte[7];
              bit_cnt_r <= 4'h1;
              state_r   <= ST_RDATA;
            end else begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_CMD;
            end
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            state_r  <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_r == BYTE_BITS) begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_RDATA_ACK;
            end else begin
              sda_oe_r  <= ~shift_r[7];
              shift_r   <= {shift_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            master_ack_r <= ~sda_sync_r[1];
          end else if (scl_fall) begin
            if (master_ack_r) begin
              shift_r   <= {rd_byte[6:0], 1'b0};
              sda_oe_r  <= ~rd_byte[7];
              bit_cnt_r <= 4'h1;
              state_r   <= ST_RDATA;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Open drain: the pin is only ever pulled low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_out_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
    end
  end

  // ****************************************
  // Writable registers
  // ****************************************
  assign wr_fire = (state_r == ST_WDATA) & byte_done;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // RQ14: all ports start off
      port_mode_r <= PORT_MODE_RESET;
      disc_en_r   <= DISC_ENABLE_RESET;
    end else if (wr_fire) begin
      // RQ4: mode write
      if (cmd_r == CMD_PORT_MODE) begin
        port_mode_r <= shift_r;
      end
      // RQ11: disconnect enable write
      if (cmd_r == CMD_DISC_ENABLE) begin
        disc_en_r <= shift_r[3:0];
      end
    end
  end

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [31:0] tick_cnt_r;
  logic        tick_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 32'(MS_TICK_CYCLES - 1)) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      tick_r     <= 1'b0;
    end
  end

  // ****************************************
  // Per-port mode, power state and disconnect
  // ****************************************
  logic [3:0] off_hold_r;
  logic [3:0] auto_en_r;
  logic [3:0] pwr_req_r;
  logic [3:0] disc_fault_r;
  logic [3:0] port_on_r;
  logic [3:0] pgood_r;
  logic [3:0] pon_chg_r;
  logic [3:0] pg_chg_r;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [1:0]  mode;
    logic        is_off;
    logic        disc_trip;
    logic        on_nxt;
    logic        pg_nxt;
    logic [15:0] low_ms_r;
    logic [4:0]  high_ms_r;

    // RQ5: per-port mode pair
    assign mode      = port_mode_r[p*MODE_W +: MODE_W];
    assign is_off    = (mode == MODE_OFF);
    // RQ13: timeout after low current
    // Gated here too, so a one-tick timeout cannot trip a disabled or unpowered port
    assign disc_trip = tick_r & current_low[p] & disc_en_r[p] & port_on_r[p] & ~is_off &
                       (low_ms_r == 16'(DISC_TIMEOUT - 1));
    // RQ9: off mode or fault drops power
    assign on_nxt    = (is_off | disc_trip | power_off_set[p]) ? 1'b0 :
                       (power_on_set[p] ? 1'b1 : port_on_r[p]);
    assign pg_nxt    = ~on_nxt ? 1'b0 : (power_good_set[p] ? 1'b1 : pgood_r[p]);

    // RQ13: disconnect timer
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        low_ms_r  <= 16'h0;
        high_ms_r <= 5'h0;
      end else if (is_off || !disc_en_r[p] || !port_on_r[p] || disc_trip) begin
        low_ms_r  <= 16'h0;
        high_ms_r <= 5'h0;
      end else if (tick_r) begin
        if (current_low[p]) begin
          low_ms_r  <= low_ms_r + 16'h1;
          high_ms_r <= 5'h0;
        end else if (high_ms_r == 5'(DISC_HOLD_MS - 1)) begin
          // Sustained load restarts the count; it never goes below zero
          low_ms_r  <= 16'h0;
          high_ms_r <= 5'h0;
        end else begin
          high_ms_r <= high_ms_r + 5'h1;
        end
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        off_hold_r[p]   <= 1'b1;
        auto_en_r[p]    <= 1'b0;
        pwr_req_r[p]    <= 1'b0;
        disc_fault_r[p] <= 1'b0;
        port_on_r[p]    <= 1'b0;
        pgood_r[p]      <= 1'b0;
      end else begin
        // RQ7: hold events cleared
        // RQ8: clear results and enables
        off_hold_r[p]   <= is_off;
        // RQ6: no automatic steps in manual
        auto_en_r[p]    <= ~is_off & (mode != MODE_MANUAL);
        // RQ6: power only on host command
        pwr_req_r[p]    <= power_on_cmd[p] & ~is_off & ~port_on_r[p];
        disc_fault_r[p] <= disc_trip;
        port_on_r[p]    <= on_nxt;
        pgood_r[p]      <= pg_nxt;
      end
    end

    // RQ10: change events, set wins over clear
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pon_chg_r[p] <= 1'b0;
        pg_chg_r[p]  <= 1'b0;
      end else begin
        pon_chg_r[p] <= (on_nxt != port_on_r[p]) | (pon_chg_r[p] & ~change_event_clear[p]);
        pg_chg_r[p]  <= (pg_nxt != pgood_r[p]) | (pg_chg_r[p] & ~change_event_clear[p]);
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sda_out                 = sda_out_r;
  assign sda_oe                  = sda_oe_r;
  assign port_mode               = port_mode_r;
  assign dc_drop_off_enable      = disc_en_r;
  assign off_hold                = off_hold_r;
  assign auto_cycle_en           = auto_en_r;
  assign power_on_req            = pwr_req_r;
  assign disconnect_fault_flag   = disc_fault_r;
  assign port_on_flag            = port_on_r;
  assign power_good_flag         = pgood_r;
  assign port_on_change_event    = pon_chg_r;
  assign power_good_change_event = pg_chg_r;

endmodule

/* tb/port_mode_checker_sva.sv */
// Assertions on the port mode register block outputs
module port_mode_checker
  import pse_regs_pkg::*;
(
  input wire logic       clk,                     // Clock
  input wire logic       nrst,                    // Reset
  input wire logic [7:0] port_mode,               // Modes
  input wire logic [3:0] off_hold,                // Off hold
  input wire logic [3:0] auto_cycle_en,           // Auto
  input wire logic [3:0] power_on_cmd,            // Power cmd
  input wire logic [3:0] power_on_req,            // Power req
  input wire logic [3:0] port_on_flag,            // Port on
  input wire logic [3:0] power_good_flag,         // Good
  input wire logic [3:0] port_on_change_event,    // On change
  input wire logic [3:0] power_good_change_event, // Good change
  input wire logic [3:0] disconnect_fault_flag,   // Fault
  input wire logic [3:0] dc_drop_off_enable       // Enable
);
  logic [3:0] mode_off;
  logic [3:0] mode_auto;
  assign mode_off = {port_mode[7:6] == MODE_OFF, port_mode[5:4] == MODE_OFF,
                     port_mode[3:2] == MODE_OFF, port_mode[1:0] == MODE_OFF};
  assign mode_auto = {port_mode[7], port_mode[5], port_mode[3], port_mode[1]};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ****************
  // Checks
  // ****************
  off_track_a: assert property (off_hold == $past(mode_off))
    else $error("off_hold wrong");
  auto_track_a: assert property (auto_cycle_en == $past(mode_auto))
    else $error("auto_cycle_en wrong");
  power_req_a: assert property (power_on_req == $past(power_on_cmd & ~mode_off & ~port_on_flag))
    else $error("power_on_req wrong");
  off_clears_a: assert property (((port_on_flag | power_good_flag) & $past(mode_off)) == 4'h0)
    else $error("flags kept in off mode");
  on_change_a: assert property (($past(port_on_flag & mode_off) & ~port_on_change_event) == 4'h0)
    else $error("port-on change missed");
  good_change_a: assert property (($past(power_good_flag & mode_off) & ~power_good_change_event) == 4'h0)
    else $error("power-good change missed");
  fault_pulse_a: assert property ((disconnect_fault_flag & $past(disconnect_fault_flag)) == 4'h0)
    else $error("fault longer than one cycle");
  fault_enable_a: assert property ((disconnect_fault_flag & ~dc_drop_off_enable) == 4'h0)
    else $error("fault while disabled");
  fault_off_a: assert property (|disconnect_fault_flag |=> (port_on_flag & $past(disconnect_fault_flag)) == 4'h0)
    else $error("port on after fault");
endmodule

bind pse_port_mode_regs port_mode_checker chk (.clk(clk), .nrst(nrst), .port_mode(port_mode),
  .off_hold(off_hold), .auto_cycle_en(auto_cycle_en), .power_on_cmd(power_on_cmd),
  .power_on_req(power_on_req), .port_on_flag(port_on_flag), .power_good_flag(power_good_flag),
  .port_on_change_event(port_on_change_event), .power_good_change_event(power_good_change_event),
  .disconnect_fault_flag(disconnect_fault_flag), .dc_drop_off_enable(dc_drop_off_enable));

/* tb/serial_host_model.sv */
// Behavioural serial bus master for the register block
module serial_host_model (
  input  wire logic clk,      // Clock
  input  wire logic sda_wire, // Resolved data line
  output logic      scl,      // Serial clock
  output logic      sda_low   // Pull data low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Eight clocks a phase, double the slave's minimum
  task automatic phase();
    repeat (8) @(negedge clk);
  endtask
  task automatic start();
    sda_low = 1'b0;
    phase();
    scl = 1'b1;
    phase();
    sda_low = 1'b1;
    phase();
    scl = 1'b0;
    phase();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    phase();
    scl = 1'b1;
    phase();
    sda_low = 1'b0;
    phase();
  endtask
  // Data moves only while clock is low
  task automatic bit_io(input logic b, output logic seen);
    sda_low = ~b;
    phase();
    scl = 1'b1;
    phase();
    seen = sda_wire;
    scl = 1'b0;
    phase();
  endtask
  task automatic byte_io(input logic [7:0] b, output logic [7:0] got);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], got[i]);
    end
  endtask
  task automatic send(input logic [7:0] b, inout logic ok);
    logic [7:0] g;
    logic       s;
    byte_io(b, g);
    bit_io(1'b1, s);
    ok = ok & ~s;
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    send({a, 1'b0}, ok);
    send(c, ok);
    send(d, ok);
    stop();
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d, output logic ok);
    logic s;
    ok = 1'b1;
    start();
    send({a, 1'b0}, ok);
    send(c, ok);
    start();
    send({a, 1'b1}, ok);
    byte_io(8'hFF, d);
    bit_io(1'b1, s);
    stop();
  endtask
endmodule

/* tb/pse_port_mode_and_address_regs_tb_top.sv */
// Self-checking bench for the port mode and strap address registers
module pse_port_mode_and_address_regs_tb_top
  import pse_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          TICKS = 10;
  localparam int          TMO   = 5;
  localparam logic        LSB   = 1'b1;
  localparam logic [23:0] TBL   = 24'h5AE41B;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       scl, host_low, sda_out, sda_oe, ack;
  logic [3:0] strap, pcmd, pon, poff, pgood, clow, cclr;
  logic [3:0] dcen, hold, auto, preq, dfault, pon_f, pg_f, pon_c, pg_c;
  logic [7:0] pmode, m, got;
  int         mismatches = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  int         seed = 32'h8b566fe4;
  wire        sda_wire = ~((sda_oe & ~sda_out) | host_low);

  pse_port_mode_regs #(.ADDR_LSB(LSB), .MS_TICK_CYCLES(TICKS), .DISC_TIMEOUT(TMO)) dut (
    .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_strap_pins(strap), .power_on_cmd(pcmd), .power_on_set(pon), .power_off_set(poff),
    .power_good_set(pgood), .current_low(clow), .change_event_clear(cclr), .port_mode(pmode),
    .dc_drop_off_enable(dcen), .off_hold(hold), .auto_cycle_en(auto), .power_on_req(preq),
    .disconnect_fault_flag(dfault), .port_on_flag(pon_f), .power_good_flag(pg_f),
    .port_on_change_event(pon_c), .power_good_change_event(pg_c));
  serial_host_model host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(host_low));

  always #5 clk = ~clk;
  // Run needs about 21500 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end
  // ****************
  // Helpers
  // ****************
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [6:0] own();
    return {ADDR_PREFIX, strap, LSB};
  endfunction
  function automatic logic [3:0] off_of(input logic [7:0] v);
    for (int p = 0; p < 4; p++) off_of[p] = v[2*p+:2] == MODE_OFF;
  endfunction
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input logic e);
    host.write_reg(a, c, d, ack);
    check("write ack", {7'h0, e}, {7'h0, ack});
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    host.read_reg(own(), c, got, ack);
    check("read ack", 8'h01, {7'h0, ack});
    check("read data", e, got);
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    {strap, pcmd, pon, poff, pgood, clow, cclr} = '0;
    repeat (8) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    repeat (4) @(negedge clk);
    check("mode", PORT_MODE_RESET, pmode);
    check("hold", 8'h0F, {4'h0, hold});
    rd(CMD_PORT_MODE, PORT_MODE_RESET);
    for (int i = 0; i < 3; i++) begin
      strap = 4'($random(seed));
      repeat (4) @(negedge clk);
      rd(CMD_STRAP_STATUS, {1'b0, strap, LSB, STATUS_LOW_ZEROS});
      wr(own(), CMD_STRAP_STATUS, 8'hFF, 1'b1);
      rd(CMD_STRAP_STATUS, {1'b0, strap, LSB, STATUS_LOW_ZEROS});
      wr({ADDR_PREFIX, strap, ~LSB}, CMD_PORT_MODE, 8'hFF, 1'b0);
    end
    check("mode", 8'h00, pmode);
    for (int i = 0; i < 4; i++) begin
      m = (i < 3) ? TBL[8*i+:8] : 8'($random(seed));
      wr((i == 2) ? BROADCAST_ADDR : own(), CMD_PORT_MODE, m, 1'b1);
      check("mode", m, pmode);
      check("hold", {4'h0, off_of(m)}, {4'h0, hold});
      check("auto", {4'h0, m[7], m[5], m[3], m[1]}, {4'h0, auto});
      rd(CMD_PORT_MODE, m);
    end
    wr(own(), CMD_DISC_ENABLE, 8'hA5, 1'b1);
    check("enable", 8'h05, {4'h0, dcen});
    rd(CMD_DISC_ENABLE, 8'h05);
    wr(own(), CMD_PORT_MODE, 8'h55, 1'b1);
    @(negedge clk) pcmd = 4'h3;
    @(negedge clk) pon = 4'h3;
    check("req", 8'h03, {4'h0, preq});
    @(negedge clk) pgood = 4'h3;
    @(negedge clk) {pcmd, pon, pgood, cclr} = 16'h000F;
    @(negedge clk) cclr = 4'h0;
    check("on", 8'h03, {4'h0, pon_f});
    check("events", 8'h00, {pg_c, pon_c});
    wr(own(), CMD_PORT_MODE, 8'h54, 1'b1);
    check("on good", 8'h22, {pg_f, pon_f});
    check("events", 8'h11, {pg_c, pon_c});
    check("hold", 8'h01, {4'h0, hold});
    @(negedge clk) pcmd = 4'h1;
    @(negedge clk) check("req", 8'h00, {4'h0, preq});
    pcmd = 4'h0;
    clow = 4'h2;
    repeat (TICKS * TMO * 3) @(negedge clk);
    check("on", 8'h02, {4'h0, pon_f});
    clow = 4'h0;
    wr(own(), CMD_DISC_ENABLE, 8'h02, 1'b1);
    clow = 4'h2;
    for (int n = 0; n < 400 && dfault !== 4'h2; n++) @(negedge clk);
    check("fault", 8'h02, {4'h0, dfault});
    @(negedge clk);
    check("on", 8'h00, {4'h0, pon_f});
    @(negedge clk) {pon, pgood} = 8'h41;
    @(negedge clk) check("on good", 8'h04, {pg_f, pon_f});
    {pon, poff} = 8'h44;
    @(negedge clk) {pon, poff, pgood} = 12'h000;
    check("on good", 8'h00, {pg_f, pon_f});
    complete_run();
  end
endmodule
